/* File: hotswap_fault_supervisor.sv */
// Hot-swap fault supervisor: limit, breaker, fault timer, retry, lockout, flags
`timescale 1ns/1ps

module hotswap_fault_supervisor (
  input wire logic clk,
  input wire logic rst,
  input wire hotswap_pkg::cmp_t cmp_async,
  input wire logic [7:0] reg_addr,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [15:0] reg_wdata,
  output logic [15:0] reg_rdata,
  output hotswap_pkg::drive_t drive,
  output logic alert_output_n
);

  hotswap_pkg::cmp_t cmp;
  hotswap_pkg::state_t state_q;
  hotswap_pkg::state_t state_d;
  hotswap_pkg::drive_t drive_d;

  logic [7:0] operation_q;
  logic [15:0] alert_mask_q;
  logic [7:0] prot_setup_q;
  logic oc_flag_q;
  logic cb_flag_q;
  logic uv_flag_q;
  logic ov_flag_q;
  logic brk_prev_q;
  logic [2:0] cycle_q;
  logic [4:0] attempts_q;
  logic [15:0] rdata_d;
  logic [15:0] diag_word;
  logic [7:0] input_word;
  logic [15:0] summary_word;
  logic [7:0] vendor_word;

  logic cl_high_sel;
  logic cb_high_sel;
  logic current_limiting;
  logic breaker_active;
  logic limiting;
  logic lockout;
  logic output_on;
  logic clear_faults;
  logic timeout;
  logic brk_event;
  logic [2:0] retry_code;
  logic retry_inf;
  logic [4:0] retry_max;
  logic retries_left;

  // Comparators and straps leave the analog domain here
  // synchronise comparator inputs
  sync_bank #(
    .W($bits(hotswap_pkg::cmp_t))
  ) u_sync (
    .clk(clk),
    .rst(rst),
    .async_in(cmp_async),
    .sync_out(cmp)
  );

  // Write decode used by several register processes
  function automatic logic wr_hit(input logic [7:0] addr, input logic [7:0] ofs, input logic wr);
    wr_hit = wr && (addr == ofs);
  endfunction

  // Retry code to maximum attempts; bit 5 means unlimited
  function automatic logic [5:0] retry_decode(input logic [2:0] code);
    unique case (code)
      hotswap_pkg::RETRY_0: retry_decode = 6'h00;
      hotswap_pkg::RETRY_1: retry_decode = 6'h01;
      hotswap_pkg::RETRY_2: retry_decode = 6'h02;
      hotswap_pkg::RETRY_4: retry_decode = 6'h04;
      hotswap_pkg::RETRY_8: retry_decode = 6'h08;
      hotswap_pkg::RETRY_16: retry_decode = 6'h10;
      hotswap_pkg::RETRY_INF: retry_decode = 6'h20;
      default: retry_decode = 6'h00;
    endcase
  endfunction

  assign cl_high_sel = prot_setup_q[hotswap_pkg::SET_CL_OVR_BIT] ?
                       prot_setup_q[hotswap_pkg::SET_CL_VAL_BIT] : cmp.limit_select_pin;
  assign cb_high_sel = prot_setup_q[hotswap_pkg::SET_CB_OVR_BIT] ?
                       prot_setup_q[hotswap_pkg::SET_CB_VAL_BIT] : cmp.breaker_select_pin;
  assign current_limiting = cl_high_sel ? cmp.sense_over_46mv : cmp.sense_over_25mv;
  // breaker comparator per limit and ratio
  assign breaker_active = cmp.breaker_hit[{cl_high_sel, cb_high_sel}];
  assign limiting = current_limiting || cmp.power_limit_hit || breaker_active;

  // lockout while under or over voltage
  assign lockout = !cmp.uv_above || cmp.ov_above;
  assign output_on = operation_q[hotswap_pkg::OP_ON_BIT] && cmp.insertion_done;
  assign clear_faults = wr_hit(reg_addr, hotswap_pkg::OFS_CLEAR_FAULTS, reg_wr);
  assign brk_event = breaker_active && !brk_prev_q;
  assign timeout = (state_q == hotswap_pkg::ST_TIMING) && cmp.timer_above_1v7;

  // retry count from pin or setup
  assign retry_code = prot_setup_q[hotswap_pkg::SET_RETRY_LSB +: hotswap_pkg::SET_RETRY_W];
  always_comb begin
    logic [5:0] dec;
    dec = 6'h00;
    if (retry_code == hotswap_pkg::RETRY_PIN) begin
      dec = cmp.retry_select_n ? 6'h00 : 6'h20;
    end else begin
      dec = retry_decode(retry_code);
    end
    retry_inf = dec[5];
    retry_max = dec[4:0];
  end
  assign retries_left = retry_inf || (attempts_q < retry_max);

  // Fault sequencing
  always_comb begin
    state_d = state_q;
    unique case (state_q)
      hotswap_pkg::ST_IDLE: begin
        if (!lockout && output_on) begin
          state_d = hotswap_pkg::ST_RUN;
        end
      end
      hotswap_pkg::ST_RUN: begin
        if (limiting) begin
          state_d = hotswap_pkg::ST_TIMING;
        end
      end
      hotswap_pkg::ST_TIMING: begin
        if (cmp.timer_above_1v7) begin
          state_d = retries_left ? hotswap_pkg::ST_RETRY_DOWN : hotswap_pkg::ST_LATCHED;
        end else if (!limiting) begin
          state_d = hotswap_pkg::ST_RUN;
        end
      end
      hotswap_pkg::ST_RETRY_DOWN: begin
        // eighth ramp ends at 0.3 V
        if (cycle_q == hotswap_pkg::RESTART_CYCLES) begin
          if (!cmp.timer_above_0v3) begin
            state_d = hotswap_pkg::ST_RUN;
          end
        end else if (!cmp.timer_above_1v0) begin
          state_d = hotswap_pkg::ST_RETRY_UP;
        end
      end
      hotswap_pkg::ST_RETRY_UP: begin
        if (cmp.timer_above_1v7) begin
          state_d = hotswap_pkg::ST_RETRY_DOWN;
        end
      end
      hotswap_pkg::ST_LATCHED: begin
        // restart only with timer below 0.3 V
        if (!cmp.uv_above && !cmp.timer_above_0v3) begin
          state_d = hotswap_pkg::ST_IDLE;
        end
      end
    endcase
    if (state_q != hotswap_pkg::ST_LATCHED && (lockout || !output_on)) begin
      state_d = hotswap_pkg::ST_IDLE;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      state_q <= hotswap_pkg::ST_IDLE;
    end else begin
      state_q <= state_d;
    end
  end

  // Restart ramp counter
  always_ff @(posedge clk) begin
    if (rst) begin
      cycle_q <= 3'h0;
    end else if (state_q == hotswap_pkg::ST_TIMING) begin
      cycle_q <= 3'h0;
    end else if (state_q == hotswap_pkg::ST_RETRY_DOWN && state_d == hotswap_pkg::ST_RETRY_UP) begin
      cycle_q <= cycle_q + 3'h1;
    end
  end

  // Attempts since the last clean run; saturates
  // fault after restart repeats timeout
  always_ff @(posedge clk) begin
    if (rst) begin
      attempts_q <= 5'h00;
    end else if (state_q == hotswap_pkg::ST_IDLE ||
                 (state_q == hotswap_pkg::ST_TIMING && state_d == hotswap_pkg::ST_RUN)) begin
      attempts_q <= 5'h00;
    end else if (timeout && retries_left && attempts_q != 5'h1F) begin
      attempts_q <= attempts_q + 5'h01;
    end
  end

  // Analog drive selection
  always_comb begin
    drive_d = '0;
    unique case (state_d)
      hotswap_pkg::ST_IDLE: begin
        drive_d.gate_pulldown_2ma = 1'b1;
        drive_d.timer_sink_1m9a = 1'b1;
      end
      hotswap_pkg::ST_RUN: begin
        // gate on with 22 uA source
        drive_d.gate_source_22ua = 1'b1;
        drive_d.timer_sink_1m9a = 1'b1;
      end
      hotswap_pkg::ST_TIMING: begin
        drive_d.timer_source_90ua = 1'b1;
        drive_d.gate_regulate = 1'b1;
      end
      hotswap_pkg::ST_RETRY_DOWN: begin
        // gate held off at 2 mA
        drive_d.gate_pulldown_2ma = 1'b1;
        drive_d.timer_sink_2u8a = 1'b1;
      end
      hotswap_pkg::ST_RETRY_UP: begin
        drive_d.gate_pulldown_2ma = 1'b1;
        drive_d.timer_source_90ua = 1'b1;
      end
      hotswap_pkg::ST_LATCHED: begin
        drive_d.gate_pulldown_2ma = 1'b1;
        drive_d.timer_sink_2u8a = 1'b1;
      end
    endcase
    if (breaker_active) begin
      drive_d.gate_pulldown_190ma = 1'b1;
      drive_d.gate_source_22ua = 1'b0;
      drive_d.gate_regulate = 1'b0;
    end
    drive_d.uv_hyst_23ua = !cmp.uv_above;
    drive_d.ov_hyst_23ua = cmp.ov_above;
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      drive <= '0;
    end else begin
      drive <= drive_d;
    end
  end

  // Software writable registers
  always_ff @(posedge clk) begin
    if (rst) begin
      operation_q <= hotswap_pkg::RST_OPERATION;
      alert_mask_q <= hotswap_pkg::RST_ALERT_MASK;
      prot_setup_q <= hotswap_pkg::RST_PROT_SETUP;
    end else begin
      if (wr_hit(reg_addr, hotswap_pkg::OFS_OPERATION, reg_wr)) begin
        operation_q <= reg_wdata[7:0];
      end
      if (wr_hit(reg_addr, hotswap_pkg::OFS_ALERT_MASK, reg_wr)) begin
        alert_mask_q <= reg_wdata;
      end
      if (wr_hit(reg_addr, hotswap_pkg::OFS_PROT_SETUP, reg_wr)) begin
        prot_setup_q <= reg_wdata[7:0];
      end
    end
  end

  // Sticky fault flags; a set in the clearing cycle survives
  // hold until cleared
  always_ff @(posedge clk) begin
    if (rst) begin
      oc_flag_q <= 1'b0;
      cb_flag_q <= 1'b0;
      uv_flag_q <= 1'b0;
      ov_flag_q <= 1'b0;
      brk_prev_q <= 1'b0;
    end else begin
      brk_prev_q <= breaker_active;
      oc_flag_q <= timeout || (oc_flag_q && !clear_faults);
      cb_flag_q <= brk_event || (cb_flag_q && !clear_faults);
      uv_flag_q <= !cmp.uv_above || (uv_flag_q && !clear_faults);
      ov_flag_q <= cmp.ov_above || (ov_flag_q && !clear_faults);
    end
  end

  // Status views
  always_comb begin
    input_word = 8'h00;
    input_word[hotswap_pkg::INP_OC_BIT] = oc_flag_q;
    input_word[hotswap_pkg::INP_UV_BIT] = uv_flag_q;
    input_word[hotswap_pkg::INP_OV_BIT] = ov_flag_q;
    vendor_word = 8'h00;
    vendor_word[hotswap_pkg::VND_CB_BIT] = cb_flag_q;
    summary_word = 16'h0000;
    summary_word[hotswap_pkg::SUM_INPUT_BIT] = |input_word;
    summary_word[hotswap_pkg::SUM_OTHER_BIT] = |vendor_word;
    diag_word = 16'h0000;
    diag_word[hotswap_pkg::DIAG_OC_BIT] = oc_flag_q;
    diag_word[hotswap_pkg::DIAG_CB_BIT] = cb_flag_q;
    diag_word[hotswap_pkg::DIAG_LATCHED_BIT] = (state_q == hotswap_pkg::ST_LATCHED);
    diag_word[hotswap_pkg::DIAG_UV_BIT] = uv_flag_q;
    diag_word[hotswap_pkg::DIAG_OV_BIT] = ov_flag_q;
  end

  // Read port; unmapped codes read zero
  always_comb begin
    rdata_d = 16'h0000;
    unique case (reg_addr)
      hotswap_pkg::OFS_OPERATION: rdata_d = {8'h00, operation_q};
      hotswap_pkg::OFS_STATUS_SUMMARY: rdata_d = summary_word;
      hotswap_pkg::OFS_INPUT_FAULT: rdata_d = {8'h00, input_word};
      hotswap_pkg::OFS_VENDOR_FAULT: rdata_d = {8'h00, vendor_word};
      hotswap_pkg::OFS_ALERT_MASK: rdata_d = alert_mask_q;
      hotswap_pkg::OFS_PROT_SETUP: rdata_d = {8'h00, prot_setup_q};
      hotswap_pkg::OFS_DIAG_FLAGS: rdata_d = diag_word;
      default: rdata_d = 16'h0000;
    endcase
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      reg_rdata <= 16'h0000;
    end else if (reg_rd) begin
      reg_rdata <= rdata_d;
    end
  end

  // Alert pin, latched-off state excluded since it is not a cleared fault
  // unmasked sources pull alert low
  always_ff @(posedge clk) begin
    if (rst) begin
      alert_output_n <= 1'b1;
    end else begin
      alert_output_n <= !(|(diag_word & ~alert_mask_q &
                          ~(16'h0001 << hotswap_pkg::DIAG_LATCHED_BIT)));
    end
  end

endmodule

/* File: hotswap_fault_supervisor_bench.sv */
// Self-checking bench for the hot-swap fault supervisor
`timescale 1ns/1ps
module hotswap_fault_supervisor_bench;
  localparam int W_ALERT = 0;
  localparam int W_OVH = 1;
  localparam int W_SINK28 = 3;
  localparam int W_SINK19 = 4;
  localparam int W_SRC90 = 5;
  localparam int W_PD190 = 6;
  localparam int W_REG = 8;
  localparam int W_SRC22 = 9;
  logic clk, rst, reg_wr, reg_rd, alert_output_n, t17, t10, t03;
  logic [7:0] reg_addr;
  logic [15:0] reg_wdata, reg_rdata, rv;
  logic [9:0] obs;
  hotswap_pkg::cmp_t cin, cmp;
  hotswap_pkg::drive_t drive;
  int fail_count, cmp_count, rises, ex;
  assign obs = {drive, ~alert_output_n};
  always_comb begin
    cmp = cin;
    cmp.timer_above_1v7 = t17;
    cmp.timer_above_1v0 = t10;
    cmp.timer_above_0v3 = t03;
  end
  hotswap_fault_supervisor dut_u (
    .clk(clk), .rst(rst), .cmp_async(cmp), .reg_addr(reg_addr), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .drive(drive),
    .alert_output_n(alert_output_n)
  );
  hotswap_power_stage stage_u (
    .clk(clk), .rst(rst), .drive(drive), .timer_above_1v7(t17),
    .timer_above_1v0(t10), .timer_above_0v3(t03)
  );
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  task automatic end_sim();
    $display("comparisons %0d mismatches %0d", cmp_count, fail_count);
    if (fail_count == 0 && cmp_count > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask
  task automatic check(input string what, input logic [15:0] exp, input logic [15:0] got);
    cmp_count++;
    if (got !== exp) begin
      fail_count++;
      $display("BAD %s expected %h seen %h", what, exp, got);
    end
  endtask
  // Called at a falling edge; one strobe cycle, then one idle cycle
  // Idle cycle keeps back-to-back calls from re-driving the strobe in one step
  task automatic acc(input logic w, input logic [7:0] a, input logic [15:0] d);
    reg_addr = a;
    reg_wdata = d;
    reg_wr = w;
    reg_rd = !w;
    @(negedge clk);
    rv = reg_rdata;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    @(negedge clk);
  endtask
  task automatic rdchk(input string what, input logic [7:0] a, input logic [15:0] exp);
    acc(1'b0, a, 16'h0000);
    check(what, exp, rv);
  endtask
  task automatic wait_bit(input int idx, input logic val, input int lim);
    int n;
    n = 0;
    while (obs[idx] !== val && n < lim) begin
      @(negedge clk);
      n++;
    end
    check("wait", {15'h0000, val}, {15'h0000, obs[idx]});
    if (obs[idx] !== val) end_sim();
  endtask
  task automatic count(input int idx, input int k);
    logic prev;
    rises = 0;
    repeat (k) begin
      prev = obs[idx];
      @(negedge clk);
      if (!prev && obs[idx] === 1'b1) rises++;
    end
  endtask
  // Timer must fall below 0.3 V before the UV pulse can restart
  task automatic recover();
    repeat (200) @(negedge clk);
    cin.uv_above = 1'b0;
    repeat (5) @(negedge clk);
    cin.uv_above = 1'b1;
    repeat (4) @(negedge clk);
    acc(1'b1, hotswap_pkg::OFS_CLEAR_FAULTS, 16'h0000);
    acc(1'b1, hotswap_pkg::OFS_OPERATION, 16'h0000);
    wait_bit(W_SRC22, 1'b0, 6);
    acc(1'b1, hotswap_pkg::OFS_OPERATION, 16'h0080);
    wait_bit(W_SRC22, 1'b1, 20);
    wait_bit(W_ALERT, 1'b0, 4);
  endtask
  initial begin
    repeat (90000) @(posedge clk);
    fail_count++;
    end_sim();
  end
  initial begin
    cin = '0;
    cin.uv_above = 1'b1;
    cin.insertion_done = 1'b1;
    cin.retry_select_n = 1'b1;
    rst = 1'b1;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    reg_addr = 8'h00;
    reg_wdata = 16'h0000;
    repeat (3) @(negedge clk);
    rst = 1'b0;
    repeat (4) @(negedge clk);
    rdchk("mask", hotswap_pkg::OFS_ALERT_MASK, hotswap_pkg::RST_ALERT_MASK);
    rdchk("setup", hotswap_pkg::OFS_PROT_SETUP, {8'h00, hotswap_pkg::RST_PROT_SETUP});
    rdchk("unmapped", 8'h55, 16'h0000);
    acc(1'b1, hotswap_pkg::OFS_CLEAR_FAULTS, 16'h0000);
    wait_bit(W_SRC22, 1'b1, 20);
    wait_bit(W_ALERT, 1'b0, 4);
    cin.sense_over_25mv = 1'b1;
    wait_bit(W_REG, 1'b1, 6);
    check("charge", 16'h0001, {15'h0000, obs[W_SRC90]});
    repeat (3) @(negedge clk);
    cin.sense_over_25mv = 1'b0;
    wait_bit(W_SINK19, 1'b1, 6);
    wait_bit(W_SRC22, 1'b1, 6);
    rdchk("input", hotswap_pkg::OFS_INPUT_FAULT, 16'h0000);
    acc(1'b1, hotswap_pkg::OFS_PROT_SETUP, 16'h000F);
    cin.sense_over_25mv = 1'b1;
    cin.breaker_hit = 4'h1;
    repeat (6) @(negedge clk);
    check("limit", 16'h0000, {15'h0000, obs[W_REG]});
    check("trip", 16'h0000, {15'h0000, obs[W_PD190]});
    cin.sense_over_25mv = 1'b0;
    cin.breaker_hit = 4'h8;
    wait_bit(W_PD190, 1'b1, 5);
    cin.breaker_hit = 4'hF;
    repeat (5) @(negedge clk);
    cin.breaker_hit = 4'h0;
    wait_bit(W_PD190, 1'b0, 5);
    rdchk("vendor", hotswap_pkg::OFS_VENDOR_FAULT, 16'h1 << hotswap_pkg::VND_CB_BIT);
    rdchk("diag", hotswap_pkg::OFS_DIAG_FLAGS, 16'h1 << hotswap_pkg::DIAG_CB_BIT);
    check("alert", 16'h0001, {15'h0000, obs[W_ALERT]});
    acc(1'b1, hotswap_pkg::OFS_PROT_SETUP, 16'h0000);
    acc(1'b1, hotswap_pkg::OFS_CLEAR_FAULTS, 16'h0000);
    cin.power_limit_hit = 1'b1;
    wait_bit(W_REG, 1'b1, 6);
    wait_bit(W_SINK28, 1'b1, 40);
    cin.power_limit_hit = 1'b0;
    rdchk("input", hotswap_pkg::OFS_INPUT_FAULT, 16'h1 << hotswap_pkg::INP_OC_BIT);
    rdchk("summary", hotswap_pkg::OFS_STATUS_SUMMARY, 16'h1 << hotswap_pkg::SUM_INPUT_BIT);
    ex = (1 << hotswap_pkg::DIAG_OC_BIT) | (1 << hotswap_pkg::DIAG_LATCHED_BIT);
    rdchk("diag", hotswap_pkg::OFS_DIAG_FLAGS, ex[15:0]);
    check("alert", 16'h0001, {15'h0000, obs[W_ALERT]});
    cin.uv_above = 1'b0;
    repeat (5) @(negedge clk);
    cin.uv_above = 1'b1;
    repeat (6) @(negedge clk);
    ex = ex | (1 << hotswap_pkg::DIAG_UV_BIT);
    rdchk("diag", hotswap_pkg::OFS_DIAG_FLAGS, ex[15:0]);
    ex = (1 << hotswap_pkg::INP_OC_BIT) | (1 << hotswap_pkg::INP_UV_BIT);
    rdchk("input", hotswap_pkg::OFS_INPUT_FAULT, ex[15:0]);
    recover();
    cin.retry_select_n = 1'b0;
    cin.power_limit_hit = 1'b1;
    wait_bit(W_SINK28, 1'b1, 40);
    wait_bit(W_SRC22, 1'b1, 1200);
    wait_bit(W_SINK28, 1'b1, 60);
    cin.power_limit_hit = 1'b0;
    count(W_SRC90, 1200);
    check("ramps", 16'h0007, rises[15:0]);
    check("restart", 16'h0001, {15'h0000, obs[W_SRC22]});
    acc(1'b1, hotswap_pkg::OFS_CLEAR_FAULTS, 16'h0000);
    for (int i = 0; i < 6; i++) begin
      ex = (i == 0) ? 0 : (1 << (i - 1));
      acc(1'b1, hotswap_pkg::OFS_PROT_SETUP, {9'h000, 3'(hotswap_pkg::RETRY_0 + i), 4'h0});
      rdchk("setup", hotswap_pkg::OFS_PROT_SETUP, {8'h00, 1'b0, 3'(1 + i), 4'h0});
      cin.power_limit_hit = 1'b1;
      count(W_SRC22, 800 * ex + 1000);
      cin.power_limit_hit = 1'b0;
      check("retries", ex[15:0], rises[15:0]);
      recover();
    end
    acc(1'b1, hotswap_pkg::OFS_PROT_SETUP, {9'h000, hotswap_pkg::RETRY_INF, 4'h0});
    cin.power_limit_hit = 1'b1;
    count(W_SRC22, 4000);
    check("endless", 16'h0001, {15'h0000, rises > 2});
    cin.power_limit_hit = 1'b0;
    wait_bit(W_SRC22, 1'b1, 1200);
    acc(1'b1, hotswap_pkg::OFS_PROT_SETUP, 16'h0000);
    acc(1'b1, hotswap_pkg::OFS_CLEAR_FAULTS, 16'h0000);
    acc(1'b1, hotswap_pkg::OFS_ALERT_MASK, 16'h1 << hotswap_pkg::DIAG_OV_BIT);
    cin.ov_above = 1'b1;
    wait_bit(W_OVH, 1'b1, 6);
    rdchk("input", hotswap_pkg::OFS_INPUT_FAULT, 16'h1 << hotswap_pkg::INP_OV_BIT);
    rdchk("diag", hotswap_pkg::OFS_DIAG_FLAGS, 16'h1 << hotswap_pkg::DIAG_OV_BIT);
    check("masked", 16'h0000, {15'h0000, obs[W_ALERT]});
    acc(1'b1, hotswap_pkg::OFS_ALERT_MASK, 16'h0000);
    wait_bit(W_ALERT, 1'b1, 4);
    cin.ov_above = 1'b0;
    wait_bit(W_SRC22, 1'b1, 8);
    acc(1'b1, hotswap_pkg::OFS_CLEAR_FAULTS, 16'h0000);
    wait_bit(W_ALERT, 1'b0, 4);
    end_sim();
  end
endmodule

/* File: hotswap_fault_supervisor_sva.sv */
// Port checker for the hot-swap fault supervisor
`timescale 1ns/1ps
module hotswap_fault_supervisor_sva (
  input wire logic clk,
  input wire logic rst,
  input wire hotswap_pkg::cmp_t cmp_async,
  input wire logic [7:0] reg_addr,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [15:0] reg_wdata,
  input wire logic [15:0] reg_rdata,
  input wire hotswap_pkg::drive_t drive,
  input wire logic alert_output_n
);
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  logic keep;
  // Clear and mask writes may lift the alert legally
  assign keep = !(reg_wr && (reg_addr == hotswap_pkg::OFS_CLEAR_FAULTS ||
    reg_addr == hotswap_pkg::OFS_ALERT_MASK));
  chk_breaker_trip: assert property (
    cmp_async.breaker_hit == 4'hF [*4] |-> drive.gate_pulldown_190ma)
    else $error("strong pulldown missing on breaker");
  chk_breaker_release: assert property (
    cmp_async.breaker_hit == 4'h0 [*4] |-> !drive.gate_pulldown_190ma)
    else $error("strong pulldown kept after breaker");
  chk_uv_lockout: assert property (
    (!cmp_async.uv_above) [*4] |-> drive.uv_hyst_23ua && !drive.gate_source_22ua)
    else $error("undervoltage lockout drive wrong");
  chk_ov_lockout: assert property (
    cmp_async.ov_above [*4] |-> drive.ov_hyst_23ua && !drive.gate_source_22ua)
    else $error("overvoltage lockout drive wrong");
  chk_alert_hold: assert property (
    !alert_output_n && keep && $past(keep) |=> !alert_output_n)
    else $error("alert released without clear");
  chk_setup_readback: assert property (
    reg_wr && reg_addr == hotswap_pkg::OFS_PROT_SETUP ##2
    reg_rd && reg_addr == hotswap_pkg::OFS_PROT_SETUP |=>
    reg_rdata == {8'h00, $past(reg_wdata[7:0], 3)})
    else $error("setup readback mismatch");
  chk_limit_charge: assert property (
    drive.gate_regulate |-> drive.timer_source_90ua && !drive.timer_sink_1m9a)
    else $error("limiting without timer charge");
  chk_timeout_off: assert property (
    drive.timer_sink_2u8a |-> !drive.gate_source_22ua &&
    (drive.gate_pulldown_2ma || drive.gate_pulldown_190ma))
    else $error("gate not off while timer sinks");
endmodule

bind hotswap_fault_supervisor hotswap_fault_supervisor_sva chk_u (
  .clk(clk), .rst(rst), .cmp_async(cmp_async), .reg_addr(reg_addr), .reg_wr(reg_wr),
  .reg_rd(reg_rd), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .drive(drive),
  .alert_output_n(alert_output_n)
);

/* File: hotswap_pkg.sv */
// Shared constants and carrier types for the hot-swap fault supervisor
package hotswap_pkg;

  // Register command codes
  localparam logic [7:0] OFS_OPERATION = 8'h03;
  localparam logic [7:0] OFS_CLEAR_FAULTS = 8'h04;
  localparam logic [7:0] OFS_STATUS_SUMMARY = 8'h79;
  localparam logic [7:0] OFS_INPUT_FAULT = 8'h7C;
  localparam logic [7:0] OFS_VENDOR_FAULT = 8'h80;
  localparam logic [7:0] OFS_ALERT_MASK = 8'hD8;
  localparam logic [7:0] OFS_PROT_SETUP = 8'hD9;
  localparam logic [7:0] OFS_DIAG_FLAGS = 8'hE1;

  // Reset values
  localparam logic [7:0] RST_OPERATION = 8'h80;
  localparam logic [15:0] RST_ALERT_MASK = 16'h0000;
  localparam logic [7:0] RST_PROT_SETUP = 8'h00;

  // Operation register
  localparam int OP_ON_BIT = 7;

  // Summary word
  localparam int SUM_INPUT_BIT = 13;
  localparam int SUM_OTHER_BIT = 8;

  // Input fault status
  localparam int INP_OV_BIT = 7;
  localparam int INP_UV_BIT = 4;
  localparam int INP_OC_BIT = 1;

  // Vendor fault status
  localparam int VND_CB_BIT = 0;

  // Diagnostic_flags_word; alert mask uses the same positions
  localparam int DIAG_OC_BIT = 7;
  localparam int DIAG_CB_BIT = 6;
  localparam int DIAG_LATCHED_BIT = 4;
  localparam int DIAG_UV_BIT = 3;
  localparam int DIAG_OV_BIT = 2;

  // Protection setup fields
  localparam int SET_CL_OVR_BIT = 0;
  localparam int SET_CL_VAL_BIT = 1;
  localparam int SET_CB_OVR_BIT = 2;
  localparam int SET_CB_VAL_BIT = 3;
  localparam int SET_RETRY_LSB = 4;
  localparam int SET_RETRY_W = 3;

  // Retry selection codes; zero defers to the pin
  localparam logic [2:0] RETRY_PIN = 3'h0;
  localparam logic [2:0] RETRY_0 = 3'h1;
  localparam logic [2:0] RETRY_1 = 3'h2;
  localparam logic [2:0] RETRY_2 = 3'h3;
  localparam logic [2:0] RETRY_4 = 3'h4;
  localparam logic [2:0] RETRY_8 = 3'h5;
  localparam logic [2:0] RETRY_16 = 3'h6;
  localparam logic [2:0] RETRY_INF = 3'h7;

  // Restart ramp count: falling ramps ending at 1 V before the final one
  localparam logic [2:0] RESTART_CYCLES = 3'h7;

  typedef struct packed {
    logic sense_over_25mv;
    logic sense_over_46mv;
    logic [3:0] breaker_hit;
    logic power_limit_hit;
    logic timer_above_1v7;
    logic timer_above_1v0;
    logic timer_above_0v3;
    logic uv_above;
    logic ov_above;
    logic limit_select_pin;
    logic breaker_select_pin;
    logic retry_select_n;
    logic insertion_done;
  } cmp_t;

  typedef struct packed {
    logic gate_source_22ua;
    logic gate_regulate;
    logic gate_pulldown_2ma;
    logic gate_pulldown_190ma;
    logic timer_source_90ua;
    logic timer_sink_1m9a;
    logic timer_sink_2u8a;
    logic uv_hyst_23ua;
    logic ov_hyst_23ua;
  } drive_t;

  typedef enum logic [2:0] {
    ST_IDLE,
    ST_RUN,
    ST_TIMING,
    ST_RETRY_DOWN,
    ST_RETRY_UP,
    ST_LATCHED
  } state_t;

endpackage

/* File: hotswap_power_stage.sv */
// Behavioural timer capacitor seen by the supervisor
`timescale 1ns/1ps
module hotswap_power_stage #(
  parameter int CHARGE_STEP = 100
) (
  input wire logic clk,
  input wire logic rst,
  input wire hotswap_pkg::drive_t drive,
  output logic timer_above_1v7,
  output logic timer_above_1v0,
  output logic timer_above_0v3
);
  // Millivolts; charge runs ten times faster than the weak sink to keep runs short
  int timer_mv;
  always_ff @(posedge clk) begin
    if (rst || drive.timer_sink_1m9a) begin
      timer_mv <= 0;
    end else if (drive.timer_source_90ua) begin
      timer_mv <= (timer_mv > 1700) ? timer_mv : timer_mv + CHARGE_STEP;
    end else if (drive.timer_sink_2u8a && timer_mv > 0) begin
      timer_mv <= timer_mv - 10;
    end
  end
  assign timer_above_1v7 = (timer_mv >= 1700);
  assign timer_above_1v0 = (timer_mv > 1000);
  assign timer_above_0v3 = (timer_mv > 300);
endmodule

/* File: sync_bank.sv */
// Two-flop synchroniser for a bank of asynchronous inputs
`timescale 1ns/1ps
module sync_bank #(
  parameter int W = 1
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic [W-1:0] async_in,
  output logic [W-1:0] sync_out
);

  logic [W-1:0] meta_q;

  always_ff @(posedge clk) begin
    if (rst) begin
      meta_q <= '0;
      sync_out <= '0;
    end else begin
      meta_q <= async_in;
      sync_out <= meta_q;
    end
  end

endmodule
